// file: dcws_pkg.sv
// constants, state codes and the matched-latency delay line of the dds clock and word select core
package dcws_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          ACC_W       = 32;
  localparam int          POW_W       = 14;
  localparam int          COS_ADDR_W  = 19;
  localparam int          POW_DELAY   = 2;
  localparam int          PROF_NUM    = 4;
  // register byte offsets
  localparam logic [7:0]  OFS_ONE     = 8'h00;
  localparam logic [7:0]  OFS_TWO     = 8'h04;
  localparam logic [7:0]  OFS_FTW     = 8'h08;
  localparam logic [7:0]  OFS_POW     = 8'h0c;
  localparam logic [7:0]  OFS_RISE    = 8'h10;
  localparam logic [7:0]  OFS_FALL    = 8'h14;
  localparam logic [7:0]  OFS_RATE    = 8'h18;
  localparam logic [7:0]  OFS_TERM    = 8'h1c;
  localparam logic [7:0]  OFS_COMMIT  = 8'h20;
  localparam logic [7:0]  OFS_STATUS  = 8'h24;
  localparam logic [3:0]  OFS_PROF_HI = 4'h3;
  // control_function_word_one fields
  localparam int          B_NODWELL   = 2;
  localparam int          B_CLKDIS    = 4;
  localparam int          B_CMPPD     = 6;
  localparam int          B_CLRPH     = 10;
  localparam int          B_SWEEP     = 21;
  localparam int          B_RAMDST    = 30;
  localparam int          B_RAMEN     = 31;
  // control_function_word_two fields
  localparam int          B_VCO       = 2;
  localparam int          MULT_LSB    = 3;
  localparam int          MULT_MSB    = 7;
  localparam logic [4:0]  MULT_MIN    = 5'h04;
  localparam logic [4:0]  MULT_MAX    = 5'h14;
  localparam logic [4:0]  MULT_UNITY  = 5'h01;
  // ramp rate fields
  localparam int          RATE_RISE_LSB = 0;
  localparam int          RATE_FALL_LSB = 8;
  // reset values and bus response codes
  localparam logic [31:0] ONE_ACT_RST = 32'h0000_0400;
  localparam logic [31:0] ONE_BUF_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RRESP = 3'b100
  } dcws_bus_state_type;
endpackage

module dcws_delay #(
  parameter int W = 14,
  parameter int N = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [N-1:0][W-1:0] stage;
  } dcws_dly_state_type;

  dcws_dly_state_type q;
  dcws_dly_state_type d;

  always_comb begin
    d = q;
    d.stage[0] = din;
    for (int i = 1; i < N; i++) begin
      d.stage[i] = q.stage[i-1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stage[N-1];
endmodule

// file: dcws_core.sv
// dds core: clock mode decode, buffered control words, sweep and phase datapath
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
module dcws_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        crystal_osc_select_pin,
  input  wire logic        profile_sel_bit0,
  input  wire logic        profile_sel_bit1,
  output logic             osc_enable,
  output logic             crystal_out_enable,
  output logic             pll_enable,
  output logic [4:0]       pll_mult,
  output logic             system_clock_stop,
  output logic             vco_range_sel,
  output logic             comparator_pd,
  output logic             sweep_active,
  output logic [18:0]      cos_addr
);
  typedef struct packed {
    dcws_pkg::dcws_bus_state_type bus;
    logic [31:0]                  rdata;
    logic [1:0]                   resp;
    logic [31:0]                  buf_one;
    logic [31:0]                  buf_two;
    logic [31:0]                  buf_ftw;
    logic [13:0]                  buf_pow;
    logic [31:0]                  buf_rise;
    logic [31:0]                  buf_fall;
    logic [15:0]                  buf_rate;
    logic [31:0]                  buf_term;
    logic [31:0]                  act_one;
    logic [31:0]                  act_two;
    logic [31:0]                  act_ftw;
    logic [13:0]                  act_pow;
    logic [31:0]                  act_rise;
    logic [31:0]                  act_fall;
    logic [15:0]                  act_rate;
    logic [31:0]                  act_term;
    logic [3:0][31:0]             prof;
    logic [2:0]                   pin_s1;
    logic [2:0]                   pin_s2;
    logic [1:0]                   prof_prev;
    logic [31:0]                  sweep_acc;
    logic [7:0]                   ramp_cnt;
    logic [31:0]                  ftw_sel;
    logic [31:0]                  phase_acc;
    logic [18:0]                  cos_addr;
  } dcws_core_state_type;

  dcws_core_state_type q;
  dcws_core_state_type d;
  logic                wr_go;
  logic                rd_go;
  logic                commit;
  logic                prof_change;
  logic [1:0]          prof_idx;
  logic [4:0]          mult_field;
  logic                mult_in_range;
  logic                ram_en;
  logic                ram_dst_phase;
  logic                sweep_en;
  logic [13:0]         pow_sel;
  logic [13:0]         pow_dly;
  logic [31:0]         phase_sum;
  logic [31:0]         pow_merged;
  logic [31:0]         rate_merged;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // writes need both channels present; a pending write wins over a read
  assign wr_go         = (q.bus == dcws_pkg::BUS_IDLE) && s_axi_awvalid && s_axi_wvalid;
  assign rd_go         = (q.bus == dcws_pkg::BUS_IDLE) && s_axi_arvalid && !wr_go;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = (q.bus == dcws_pkg::BUS_WRESP);
  assign s_axi_rvalid  = (q.bus == dcws_pkg::BUS_RRESP);
  assign s_axi_bresp   = q.resp;
  assign s_axi_rresp   = q.resp;
  assign s_axi_rdata   = q.rdata;
  assign pow_merged    = merge({18'h0_0000, q.buf_pow}, s_axi_wdata, s_axi_wstrb);
  assign rate_merged   = merge({16'h0000, q.buf_rate}, s_axi_wdata, s_axi_wstrb);

  assign prof_idx      = q.pin_s2[1:0];
  assign prof_change   = (q.pin_s2[1:0] != q.prof_prev);
  assign commit        = (wr_go && (s_axi_awaddr == dcws_pkg::OFS_COMMIT)) || prof_change;
  assign mult_field    = q.act_two[dcws_pkg::MULT_MSB:dcws_pkg::MULT_LSB];
  assign mult_in_range = (mult_field >= dcws_pkg::MULT_MIN) &&
                         (mult_field <= dcws_pkg::MULT_MAX);
  assign ram_en        = q.act_one[dcws_pkg::B_RAMEN];
  assign ram_dst_phase = q.act_one[dcws_pkg::B_RAMDST];
  assign sweep_en      = q.act_one[dcws_pkg::B_SWEEP];

  // clock mode: pll follows the multiplier only, clock disable raises system_clock_stop and gates both oscillator enables
  assign pll_enable         = mult_in_range;
  assign pll_mult           = mult_in_range ? mult_field : dcws_pkg::MULT_UNITY;
  assign system_clock_stop        = q.act_one[dcws_pkg::B_CLKDIS];
  assign osc_enable         = q.pin_s2[2] && !q.act_one[dcws_pkg::B_CLKDIS];
  assign crystal_out_enable = osc_enable;
  assign vco_range_sel      = q.act_two[dcws_pkg::B_VCO];
  assign comparator_pd      = q.act_one[dcws_pkg::B_CMPPD];
  assign sweep_active       = sweep_en;
  assign cos_addr           = q.cos_addr;

  // offset source, then delayed so it lines up with the registered tuning word
  assign pow_sel = (ram_en && ram_dst_phase) ? q.prof[prof_idx][31:18] : q.act_pow;

  dcws_delay #(
    .W (dcws_pkg::POW_W),
    .N (dcws_pkg::POW_DELAY)
  ) u_pow_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pow_sel),
    .dout    (pow_dly)
  );

  // offset weight is pow/2^14 of a turn, so it aligns to the accumulator msbs
  assign phase_sum = q.phase_acc + {pow_dly, 18'h0_0000};

  always_comb begin
    logic [32:0] step;
    step = 33'h0_0000_0000;
    d = q;
    // register bus
    unique case (q.bus)
      dcws_pkg::BUS_IDLE: begin
        if (wr_go) begin
          d.bus  = dcws_pkg::BUS_WRESP;
          d.resp = dcws_pkg::RESP_OKAY;
          if (s_axi_awaddr[7:4] == dcws_pkg::OFS_PROF_HI) begin
            d.prof[s_axi_awaddr[3:2]] = merge(q.prof[s_axi_awaddr[3:2]], s_axi_wdata,
                                              s_axi_wstrb);
          end else begin
            unique case (s_axi_awaddr)
              dcws_pkg::OFS_ONE:    d.buf_one  = merge(q.buf_one, s_axi_wdata, s_axi_wstrb);
              dcws_pkg::OFS_TWO:    d.buf_two  = merge(q.buf_two, s_axi_wdata, s_axi_wstrb);
              dcws_pkg::OFS_FTW:    d.buf_ftw  = merge(q.buf_ftw, s_axi_wdata, s_axi_wstrb);
              dcws_pkg::OFS_POW:    d.buf_pow  = pow_merged[13:0];
              dcws_pkg::OFS_RISE:   d.buf_rise = merge(q.buf_rise, s_axi_wdata, s_axi_wstrb);
              dcws_pkg::OFS_FALL:   d.buf_fall = merge(q.buf_fall, s_axi_wdata, s_axi_wstrb);
              dcws_pkg::OFS_RATE:   d.buf_rate = rate_merged[15:0];
              dcws_pkg::OFS_TERM:   d.buf_term = merge(q.buf_term, s_axi_wdata, s_axi_wstrb);
              dcws_pkg::OFS_COMMIT: d.resp     = dcws_pkg::RESP_OKAY;
              default:              d.resp     = dcws_pkg::RESP_SLVERR;
            endcase
          end
        end else if (rd_go) begin
          d.bus  = dcws_pkg::BUS_RRESP;
          d.resp = dcws_pkg::RESP_OKAY;
          if (s_axi_araddr[7:4] == dcws_pkg::OFS_PROF_HI) begin
            d.rdata = q.prof[s_axi_araddr[3:2]];
          end else begin
            unique case (s_axi_araddr)
              dcws_pkg::OFS_ONE:    d.rdata = q.buf_one;
              dcws_pkg::OFS_TWO:    d.rdata = q.buf_two;
              dcws_pkg::OFS_FTW:    d.rdata = q.buf_ftw;
              dcws_pkg::OFS_POW:    d.rdata = {18'h0_0000, q.buf_pow};
              dcws_pkg::OFS_RISE:   d.rdata = q.buf_rise;
              dcws_pkg::OFS_FALL:   d.rdata = q.buf_fall;
              dcws_pkg::OFS_RATE:   d.rdata = {16'h0000, q.buf_rate};
              dcws_pkg::OFS_TERM:   d.rdata = q.buf_term;
              dcws_pkg::OFS_COMMIT: d.rdata = 32'h0000_0000;
              dcws_pkg::OFS_STATUS: d.rdata = {q.phase_acc[31:16], 8'h00, prof_idx,
                                               q.act_one[dcws_pkg::B_CLRPH], sweep_en,
                                               osc_enable, system_clock_stop, pll_enable,
                                               q.pin_s2[2]};
              default: begin
                d.rdata = 32'h0000_0000;
                d.resp  = dcws_pkg::RESP_SLVERR;
              end
            endcase
          end
        end
      end
      dcws_pkg::BUS_WRESP: begin
        if (s_axi_bready) begin
          d.bus = dcws_pkg::BUS_IDLE;
        end
      end
      dcws_pkg::BUS_RRESP: begin
        if (s_axi_rready) begin
          d.bus = dcws_pkg::BUS_IDLE;
        end
      end
      default: d.bus = dcws_pkg::BUS_IDLE;
    endcase

    // pins: two flops before use, a third stage only for change detection
    d.pin_s1    = {crystal_osc_select_pin, profile_sel_bit1, profile_sel_bit0};
    d.pin_s2    = q.pin_s1;
    d.prof_prev = q.pin_s2[1:0];

    // commit moves every buffered word at once; a write in the same cycle is not included
    if (commit) begin
      d.act_one  = q.buf_one;
      d.act_two  = q.buf_two;
      d.act_ftw  = q.buf_ftw;
      d.act_pow  = q.buf_pow;
      d.act_rise = q.buf_rise;
      d.act_fall = q.buf_fall;
      d.act_rate = q.buf_rate;
      d.act_term = q.buf_term;
    end

    // linear sweep: act_ftw is the start word, act_term the terminal word, bit0 the direction
    if (!sweep_en || commit) begin
      d.sweep_acc = d.act_ftw;
      d.ramp_cnt  = d.act_rate[dcws_pkg::RATE_RISE_LSB +: 8];
    end else if (q.ramp_cnt != 8'h00) begin
      d.ramp_cnt = q.ramp_cnt - 8'h01;
    end else if (prof_idx[0]) begin
      d.ramp_cnt = q.act_rate[dcws_pkg::RATE_RISE_LSB +: 8];
      step       = {1'b0, q.sweep_acc} + {1'b0, q.act_rise};
      if (q.sweep_acc == q.act_term) begin
        // no-dwell snaps back to start, otherwise the sweep parks on terminal
        if (q.act_one[dcws_pkg::B_NODWELL]) begin
          d.sweep_acc = q.act_ftw;
        end
      end else if (step >= {1'b0, q.act_term}) begin
        d.sweep_acc = q.act_term;
      end else begin
        d.sweep_acc = step[31:0];
      end
    end else begin
      d.ramp_cnt = q.act_rate[dcws_pkg::RATE_FALL_LSB +: 8];
      step       = {1'b0, q.sweep_acc} - {1'b0, q.act_fall};
      if (step[32] || (step[31:0] <= q.act_ftw)) begin
        d.sweep_acc = q.act_ftw;
      end else begin
        d.sweep_acc = step[31:0];
      end
    end

    // tuning word source
    if (ram_en && !ram_dst_phase) begin
      d.ftw_sel = q.prof[prof_idx];
    end else if (sweep_en) begin
      d.ftw_sel = q.sweep_acc;
    end else begin
      d.ftw_sel = q.act_ftw;
    end

    // phase accumulator wraps by width; a zero word simply holds phase
    if (q.act_one[dcws_pkg::B_CLRPH]) begin
      d.phase_acc = 32'h0000_0000;
    end else begin
      d.phase_acc = q.phase_acc + q.ftw_sel;
    end
    d.cos_addr = phase_sum[31:13];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.bus     <= dcws_pkg::BUS_IDLE;
      q.buf_one <= dcws_pkg::ONE_BUF_RST;
      q.act_one <= dcws_pkg::ONE_ACT_RST;
      q.buf_two <= dcws_pkg::WORD_RST;
      q.act_two <= dcws_pkg::WORD_RST;
    end else begin
      q <= d;
    end
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence prof_pin_moved;
    q.pin_s2[1:0] != q.prof_prev;
  endsequence

  sequence active_took_buffer;
    (q.act_ftw == $past(q.buf_ftw)) && (q.act_one == $past(q.buf_one));
  endsequence

  pll_mult_a: assert property (mult_in_range |-> pll_enable && (pll_mult == mult_field))
    else $error("multiplier in range but pll not multiplying");
  pll_bypass_a: assert property (!mult_in_range |-> !pll_enable && (pll_mult == 5'h01))
    else $error("multiplier out of range but pll not bypassed");
  clk_stop_a: assert property (q.act_one[dcws_pkg::B_CLKDIS] |-> system_clock_stop && !osc_enable)
    else $error("clock disable did not stop the clock");
  osc_follow_a: assert property ($rose(q.pin_s1[2]) |=> osc_enable || system_clock_stop)
    else $error("oscillator not enabled by select pin");
  phase_step_a: assert property (!q.act_one[dcws_pkg::B_CLRPH] |=>
                                 q.phase_acc == $past(q.phase_acc) + $past(q.ftw_sel))
    else $error("phase accumulator did not add tuning word");
  phase_clear_a: assert property (q.act_one[dcws_pkg::B_CLRPH] |=> q.phase_acc == 32'h0000_0000)
    else $error("clear bit did not zero the phase");
  cos_addr_a: assert property (1'b1 |=> q.cos_addr == $past(phase_sum[31:13]))
    else $error("cosine address not top bits of phase sum");
  commit_copy_a: assert property (commit |=> active_took_buffer)
    else $error("commit did not copy buffers");
  prof_commit_a: assert property (prof_pin_moved |=> active_took_buffer)
    else $error("profile change did not commit");
  static_word_a: assert property (!ram_en && !sweep_en && !commit |=>
                                  q.ftw_sel == $past(q.act_ftw))
    else $error("static tuning word not selected");
  pow_match_a: assert property (!ram_en && $changed(q.act_pow) |=> ##1
                                pow_dly == $past(q.act_pow, 2))
    else $error("phase offset delay mismatched");
endmodule

// file: dcws_dac_sink.sv
// dac-side sample sink: reports the step between successive cosine addresses
module dcws_dac_sink (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [18:0] cos_addr,
  output logic      [18:0] step_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] prev_q;
  // takes one sample every clock and never stalls the core, as a real dac input does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 19'h00000;
      step_q <= 19'h00000;
    end else begin
      prev_q <= cos_addr;
      step_q <= cos_addr - prev_q;
    end
  end
endmodule

// file: dds_core_clock_and_word_select_tb.sv
// self-checking bench for the dds clock and word select core
module dds_core_clock_and_word_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        crystal_osc_select_pin = 1'h0, profile_sel_bit0 = 1'h0, profile_sel_bit1 = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        osc_enable, crystal_out_enable, pll_enable, system_clock_stop;
  logic        vco_range_sel, comparator_pd, sweep_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_d, freq_tuning_word, w, tw;
  logic [31:0] ram [4];
  logic [4:0]  pll_mult, m;
  logic [4:0]  mt [6] = '{5'h00, 5'h03, 5'h04, 5'h14, 5'h15, 5'h1f};
  logic [18:0] cos_addr, step_q, sa;
  logic [13:0] pw;
  logic [2:0]  b;
  int          failures = 0;
  int          checks = 0;

  always #5 aclk = ~aclk;

  dcws_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .crystal_osc_select_pin, .profile_sel_bit0, .profile_sel_bit1, .osc_enable,
    .crystal_out_enable, .pll_enable, .pll_mult, .system_clock_stop, .vco_range_sel, .comparator_pd,
    .sweep_active, .cos_addr);
  dcws_dac_sink sink (.aclk, .aresetn, .cos_addr, .step_q);

  task automatic final_report;
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [5:0] exp_pll(input logic [4:0] v);
    if (v >= dcws_pkg::MULT_MIN && v <= dcws_pkg::MULT_MAX) return {1'h1, v};
    return {1'h0, dcws_pkg::MULT_UNITY};
  endfunction

  // address and data go out together; each is dropped once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'h1) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready === 1'h1) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(posedge aclk);
    while (s_axi_arready !== 1'h1) @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // the wait covers the datapath pipe and the two-flop pin synchronisers
  task automatic commit;
    wr(dcws_pkg::OFS_COMMIT, 32'h1);
    repeat (8) @(posedge aclk);
  endtask

  initial begin
    void'($urandom(75));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(dcws_pkg::OFS_ONE);
    chk("one_buf", dcws_pkg::ONE_BUF_RST, rd_d);
    rd(dcws_pkg::OFS_STATUS);
    chk("clr_act", 32'h1, {31'h0, rd_d[5]});
    chk("cos_rst", 32'h0, {13'h0, cos_addr});
    wr(dcws_pkg::OFS_TWO, 32'h50);
    repeat (4) @(posedge aclk);
    chk("pll_buf", 32'h0, {31'h0, pll_enable});
    for (int i = 0; i < 8; i++) begin
      m = (i < 6) ? mt[i] : 5'($urandom);
      b = 3'($urandom);
      w = 32'h400;
      w[dcws_pkg::B_CLKDIS] = b[1];
      w[dcws_pkg::B_CMPPD] = b[2];
      w[dcws_pkg::B_SWEEP] = b[0];
      wr(dcws_pkg::OFS_TWO, {24'h0, m, b[0], 2'h0});
      wr(dcws_pkg::OFS_ONE, w);
      crystal_osc_select_pin <= i[0];
      // no lock wait: the pll is decoded here, not modelled
      commit;
      chk("pll", {26'h0, exp_pll(m)}, {26'h0, pll_enable, pll_mult});
      chk("vco", {31'h0, b[0]}, {31'h0, vco_range_sel});
      chk("osc", {30'h0, {2{i[0] & ~b[1]}}}, {30'h0, osc_enable, crystal_out_enable});
      chk("stop", {31'h0, b[1]}, {31'h0, system_clock_stop});
      chk("cmp_pd", {31'h0, b[2]}, {31'h0, comparator_pd});
      chk("sweep", {31'h0, b[0]}, {31'h0, sweep_active});
    end
    pw = 14'($urandom);
    freq_tuning_word = $urandom & 32'hffff_e000;
    wr(dcws_pkg::OFS_FTW, freq_tuning_word);
    wr(dcws_pkg::OFS_POW, {18'h0, pw});
    wr(dcws_pkg::OFS_ONE, 32'h400);
    commit;
    chk("pow_only", {13'h0, pw, 5'h00}, {13'h0, cos_addr});
    wr(dcws_pkg::OFS_ONE, 32'h0);
    commit;
    chk("step", {13'h0, freq_tuning_word[31:13]}, {13'h0, step_q});
    wr(dcws_pkg::OFS_FTW, 32'h0);
    commit;
    chk("hold", 32'h0, {13'h0, step_q});
    for (int k = 0; k < 4; k++) begin
      ram[k] = $urandom & 32'hffff_e000;
      wr({dcws_pkg::OFS_PROF_HI, 2'(k), 2'h0}, ram[k]);
    end
    wr(dcws_pkg::OFS_ONE, 32'hc000_0400);
    commit;
    for (int k = 0; k < 4; k++) begin
      {profile_sel_bit1, profile_sel_bit0} <= 2'(k);
      repeat (12) @(posedge aclk);
      chk("ram_pow", {13'h0, ram[k][31:18], 5'h00}, {13'h0, cos_addr});
    end
    wr(dcws_pkg::OFS_ONE, 32'h8000_0000);
    commit;
    chk("ram_ftw", {13'h0, ram[3][31:13]}, {13'h0, step_q});
    {profile_sel_bit1, profile_sel_bit0} <= 2'h1;
    repeat (12) @(posedge aclk);
    chk("pin_sel", {13'h0, ram[1][31:13]}, {13'h0, step_q});
    // sweep one delta wide: rising parks on terminal, falling on start, no-dwell bounces
    freq_tuning_word = $urandom & 32'h3fff_e000;
    w = ($urandom & 32'h0fff_e000) | 32'h0000_2000;
    tw = freq_tuning_word + w;
    wr(dcws_pkg::OFS_FTW, freq_tuning_word);
    wr(dcws_pkg::OFS_RISE, w);
    wr(dcws_pkg::OFS_FALL, w);
    wr(dcws_pkg::OFS_RATE, 32'h0);
    wr(dcws_pkg::OFS_TERM, tw);
    wr(dcws_pkg::OFS_ONE, 32'h0020_0000);
    commit;
    chk("sweep_top", {13'h0, tw[31:13]}, {13'h0, step_q});
    {profile_sel_bit1, profile_sel_bit0} <= 2'h0;
    repeat (12) @(posedge aclk);
    chk("sweep_base", {13'h0, freq_tuning_word[31:13]}, {13'h0, step_q});
    wr(dcws_pkg::OFS_ONE, 32'h0020_0004);
    {profile_sel_bit1, profile_sel_bit0} <= 2'h1;
    repeat (12) @(posedge aclk);
    sa = step_q;
    @(posedge aclk);
    chk("no_dwell", {13'h0, 19'(freq_tuning_word[31:13] + tw[31:13])}, {13'h0, 19'(sa + step_q)});
    rd(8'hfc);
    chk("unm_resp", {30'h0, dcws_pkg::RESP_SLVERR}, {30'h0, rsp});
    chk("unm_data", 32'h0, rd_d);
    final_report;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    final_report;
  end
endmodule
